// ### shared/exec_pkg.sv
// Package of opcode fields, field positions, reset values and states for the execute subset
package exec_pkg;

  // ****************************************
  // Opcode encodings (14-bit instruction word)
  // ****************************************
  localparam logic [13:0] OP_WATCHDOG_CLEAR = 14'h0064;
  localparam logic [5:0] OP_ADD_REGISTER = 6'h07; // Bits 13:8
  localparam logic [5:0] OP_AND_REGISTER = 6'h05;
  localparam logic [3:0] OP_BIT_CLEAR = 4'h4; // Bits 13:10
  localparam logic [3:0] OP_BIT_SET = 4'h5;
  localparam logic [3:0] OP_SKIP_IF_CLEAR = 4'h6;
  localparam logic [3:0] OP_SKIP_IF_SET = 4'h7;
  localparam logic [4:0] OP_ADD_IMMEDIATE = 5'h1f; // Bits 13:9
  localparam logic [5:0] OP_AND_IMMEDIATE = 6'h39;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int DEST_POS = 7;
  localparam int BIT_LSB = 7;
  localparam int ADDR_MSB = 6;
  localparam int DIGIT_POS = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic STATUS_RESET = 1'b1; // Time-out and power-down idle high

  // ****************************************
  // Execute states
  // ****************************************
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_NOP = 2'b10
  } exec_state_t;

endpackage

// ### test/test_instruction_execute_subset.sv
// Self-checking testbench for the execute subset
`timescale 1ns/100ps
module test_instruction_execute_subset;
  // ****************************************
  // Clock, stimulus and design
  // ****************************************
  logic clk = 0, rst = 1, instrValid = 0;
  logic [13:0] instrWord = '0;
  logic [7:0] fileRdata = '0, accOut, fileWdata;
  logic [6:0] fileAddr, fileWaddr;
  logic fileWe, carryFlag, digitCarryFlag, zeroFlag, timeoutFlag, powerDownFlag;
  logic watchdogClear, skipCycle;
  logic [4:0] flags;
  int err_total = 0, n_checks = 0;
  assign flags = {carryFlag, digitCarryFlag, zeroFlag, timeoutFlag, powerDownFlag};
  instruction_execute_subset i_instruction_execute_subset (.clk(clk), .rst(rst),
    .instrValid(instrValid), .instrWord(instrWord), .fileAddr(fileAddr),
    .fileRdata(fileRdata), .fileWe(fileWe), .fileWaddr(fileWaddr), .fileWdata(fileWdata),
    .accOut(accOut), .carryFlag(carryFlag), .digitCarryFlag(digitCarryFlag),
    .zeroFlag(zeroFlag), .timeoutFlag(timeoutFlag), .powerDownFlag(powerDownFlag),
    .watchdogClear(watchdogClear), .skipCycle(skipCycle));
  // 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [13:0] exp, input logic [13:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Issue at the falling edge; outputs are settled by the next falling edge
  task automatic issue(input logic [13:0] w, input logic [7:0] rd);
    instrValid = 1;
    instrWord = w;
    fileRdata = rd;
    #1 chk("fileAddr", w[6:0], fileAddr);
    @(negedge clk);
  endtask
  task automatic idle();
    instrValid = 0;
    fileRdata = 8'h5a;
    @(negedge clk);
  endtask
  // Accumulator, flags {carry, digit, zero, time-out, power-down} and write strobe in one go
  task automatic state(input logic [7:0] a, input logic [4:0] f, input logic we);
    chk("accOut", a, accOut);
    chk("flags", f, flags);
    chk("fileWe", we, fileWe);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_add_imm();
    issue({exec_pkg::OP_ADD_IMMEDIATE, 1'b0, 8'h0f}, 8'h00);
    state(8'h0f, 5'b00011, 1'b0);
    issue({exec_pkg::OP_ADD_IMMEDIATE, 1'b1, 8'h01}, 8'h00);
    state(8'h10, 5'b01011, 1'b0);
    issue({exec_pkg::OP_ADD_IMMEDIATE, 1'b0, 8'hf0}, 8'h00);
    state(8'h00, 5'b10111, 1'b0);
  endtask
  task automatic t_and_imm();
    issue({exec_pkg::OP_AND_IMMEDIATE, 8'hff}, 8'h00);
    state(8'h00, 5'b10111, 1'b0);
    issue({exec_pkg::OP_ADD_IMMEDIATE, 1'b0, 8'ha5}, 8'h00);
    issue({exec_pkg::OP_AND_IMMEDIATE, 8'h0f}, 8'h00);
    state(8'h05, 5'b00011, 1'b0);
  endtask
  task automatic t_add_reg();
    issue({exec_pkg::OP_ADD_REGISTER, 1'b1, 7'h7f}, 8'hfb);
    state(8'h05, 5'b11111, 1'b1);
    chk("fileWaddr", 7'h7f, fileWaddr);
    chk("fileWdata", 8'h00, fileWdata);
    issue({exec_pkg::OP_ADD_REGISTER, 1'b0, 7'h00}, 8'h10);
    state(8'h15, 5'b00011, 1'b0);
  endtask
  task automatic t_and_reg();
    issue({exec_pkg::OP_AND_REGISTER, 1'b1, 7'h2a}, 8'h0c);
    state(8'h15, 5'b00011, 1'b1);
    chk("fileWdata", 8'h04, fileWdata);
    issue({exec_pkg::OP_AND_REGISTER, 1'b0, 7'h2a}, 8'hea);
    state(8'h00, 5'b00111, 1'b0);
  endtask
  // Every bit index, back to back, flags must not move
  task automatic t_bits();
    for (int b = 0; b < 8; b++) begin
      issue({exec_pkg::OP_BIT_CLEAR, b[2:0], 7'h33}, 8'hff);
      state(8'h00, 5'b00111, 1'b1);
      chk("fileWdata", 8'(~(8'h01 << b)), fileWdata);
      issue({exec_pkg::OP_BIT_SET, b[2:0], 7'h4c}, 8'h00);
      chk("fileWaddr", 7'h4c, fileWaddr);
      chk("fileWdata", 8'h01 << b, fileWdata);
    end
    idle();
    state(8'h00, 5'b00111, 1'b0);
  endtask
  // Not taken, then taken; the instruction in the no-op slot must be dropped
  task automatic t_skip();
    logic [3:0] op;
    logic [7:0] rd;
    for (int i = 0; i < 2; i++) begin
      op = i ? exec_pkg::OP_SKIP_IF_SET : exec_pkg::OP_SKIP_IF_CLEAR;
      rd = i ? 8'hf7 : 8'h08;
      issue({op, 3'd3, 7'h11}, rd);
      chk("skipCycle", 1'b0, skipCycle);
      issue({op, 3'd3, 7'h11}, ~rd);
      chk("skipCycle", 1'b1, skipCycle);
      issue({exec_pkg::OP_ADD_IMMEDIATE, 1'b0, 8'h01}, 8'h00);
      chk("skipCycle", 1'b0, skipCycle);
      state(8'h00, 5'b00111, 1'b0);
    end
    idle();
  endtask
  task automatic t_watchdog();
    issue(exec_pkg::OP_WATCHDOG_CLEAR, 8'h00);
    chk("watchdogClear", 1'b1, watchdogClear);
    state(8'h00, 5'b00111, 1'b0);
    idle();
    chk("watchdogClear", 1'b0, watchdogClear);
    // An opcode outside the subset must leave everything alone
    issue(14'h3aff, 8'hff);
    state(8'h00, 5'b00111, 1'b0);
  endtask
  // ****************************************
  // Main sequence and verdict
  // ****************************************
  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 0;
    state(8'h00, 5'b00011, 1'b0);
    chk("skipCycle", 1'b0, skipCycle);
    t_add_imm();
    t_and_imm();
    t_add_reg();
    t_and_reg();
    t_bits();
    t_skip();
    t_watchdog();
    final_report();
  end
endmodule // test_instruction_execute_subset

// ### verilog/flag_calc.sv
// Adder and AND unit with carry, digit-carry and zero generation
`timescale 1ns/100ps
module flag_calc (
  // Operands
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic doAnd,
  // Result and flags
  output logic [7:0] result,
  output logic carryOut,
  output logic digitOut,
  output logic zeroOut
);

  // ****************************************
  // Arithmetic
  // ****************************************
  logic [8:0] sum;
  logic [4:0] lowSum;

  // Low nibble sum gives the carry out of bit 3
  always_comb begin
    sum = {1'b0, opA} + {1'b0, opB};
    lowSum = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
    result = doAnd ? (opA & opB) : sum[7:0];
    carryOut = sum[8];
    digitOut = lowSum[exec_pkg::DIGIT_POS];
    zeroOut = (result == 8'h00);
  end

endmodule // flag_calc

// ### verilog/instruction_execute_subset.sv
// Execute stage for add, AND, bit set/clear, bit test skip and watchdog clear
//
// Contract
// - Add immediate to accumulator, update arithmetic flags.
// - Add register, destination bit selects target.
// - AND immediate into accumulator, zero flag only.
// - AND register, destination bit selects target.
// - Clear selected register bit, flags unchanged.
// - Set selected register bit, flags unchanged.
// - Skip next if tested bit clear.
// - Skip next if tested bit set.
// - Watchdog clear zeroes counter, prescaler, sets status flags.
// - Taken skip spends a second cycle as no-op.
`timescale 1ns/100ps
module instruction_execute_subset (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction issue
  input wire logic instrValid,
  input wire logic [13:0] instrWord,
  // File register read port (combinational, same clock)
  output logic [6:0] fileAddr,
  input wire logic [7:0] fileRdata,
  // File register write
  output logic fileWe,
  output logic [6:0] fileWaddr,
  output logic [7:0] fileWdata,
  // Status and control
  output logic [7:0] accOut,
  output logic carryFlag,
  output logic digitCarryFlag,
  output logic zeroFlag,
  output logic timeoutFlag,
  output logic powerDownFlag,
  output logic watchdogClear,
  output logic skipCycle
);

  // ****************************************
  // Decode
  // ****************************************
  logic isAddImm, isAddReg, isAndImm, isAndReg, isBitClr, isBitSet;
  logic isSkipClr, isSkipSet, isWatchdogClr, destReg, testBit;
  logic [2:0] bitSel;
  logic [7:0] aluB, aluRes, bitMask;
  logic aluC, aluDigit, aluZ;
  exec_pkg::exec_state_t state_r, state_nxt;

  // Field decode; the read address goes straight out so the operand arrives this cycle
  always_comb begin
    isAddImm = instrWord[13:9] == exec_pkg::OP_ADD_IMMEDIATE;
    isAndImm = instrWord[13:8] == exec_pkg::OP_AND_IMMEDIATE;
    isAddReg = instrWord[13:8] == exec_pkg::OP_ADD_REGISTER;
    isAndReg = instrWord[13:8] == exec_pkg::OP_AND_REGISTER;
    isBitClr = instrWord[13:10] == exec_pkg::OP_BIT_CLEAR;
    isBitSet = instrWord[13:10] == exec_pkg::OP_BIT_SET;
    isSkipClr = instrWord[13:10] == exec_pkg::OP_SKIP_IF_CLEAR;
    isSkipSet = instrWord[13:10] == exec_pkg::OP_SKIP_IF_SET;
    isWatchdogClr = instrWord == exec_pkg::OP_WATCHDOG_CLEAR;
    destReg = instrWord[exec_pkg::DEST_POS];
    bitSel = instrWord[exec_pkg::BIT_LSB +: 3];
    fileAddr = instrWord[exec_pkg::ADDR_MSB:0];
    bitMask = 8'h01 << bitSel;
    testBit = fileRdata[bitSel];
    aluB = (isAddImm || isAndImm) ? instrWord[7:0] : fileRdata;
  end

  flag_calc i_flag_calc (
    .opA(accOut),
    .opB(aluB),
    .doAnd(isAndImm || isAndReg),
    .result(aluRes),
    .carryOut(aluC),
    .digitOut(aluDigit),
    .zeroOut(aluZ)
  );

  // ****************************************
  // Datapath next state
  // ****************************************
  logic [7:0] acc_nxt, fwd_nxt;
  logic [6:0] fwa_nxt;
  logic c_nxt, digit_nxt, z_nxt, to_nxt, pwr_nxt, we_nxt, wc_nxt;
  logic exec;

  // An instruction arriving during the no-op cycle is the discarded one
  always_comb begin
    exec = instrValid && (state_r == exec_pkg::ST_RUN);
    acc_nxt = accOut;
    fwd_nxt = fileWdata;
    fwa_nxt = fileWaddr;
    we_nxt = 1'b0;
    wc_nxt = 1'b0;
    c_nxt = carryFlag;
    digit_nxt = digitCarryFlag;
    z_nxt = zeroFlag;
    to_nxt = timeoutFlag; // Nothing here clears it; sleep and time-out logic sit outside
    pwr_nxt = powerDownFlag;
    state_nxt = exec_pkg::ST_RUN;
    if (exec) begin
      if (isAddImm || (isAddReg && !destReg)) begin
        acc_nxt = aluRes;
      end
      if (isAndImm || (isAndReg && !destReg)) begin
        acc_nxt = aluRes;
      end
      if ((isAddReg || isAndReg) && destReg) begin
        we_nxt = 1'b1;
        fwa_nxt = fileAddr;
        fwd_nxt = aluRes;
      end
      if (isAddImm || isAddReg) begin
        c_nxt = aluC;
        digit_nxt = aluDigit;
      end
      if (isAddImm || isAddReg || isAndImm || isAndReg) begin
        z_nxt = aluZ;
      end
      // Bit operations write back without touching any flag
      if (isBitClr) begin
        we_nxt = 1'b1;
        fwa_nxt = fileAddr;
        fwd_nxt = fileRdata & ~bitMask;
      end
      if (isBitSet) begin
        we_nxt = 1'b1;
        fwa_nxt = fileAddr;
        fwd_nxt = fileRdata | bitMask;
      end
      if ((isSkipClr && !testBit) || (isSkipSet && testBit)) begin
        state_nxt = exec_pkg::ST_NOP;
      end
      if (isWatchdogClr) begin
        wc_nxt = 1'b1;
        to_nxt = 1'b1;
        pwr_nxt = 1'b1;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // All outputs but fileAddr registered; the watchdog strobe clears counter and prescaler outside
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= exec_pkg::ST_RUN;
      accOut <= exec_pkg::ACC_RESET;
      carryFlag <= exec_pkg::FLAG_RESET;
      digitCarryFlag <= exec_pkg::FLAG_RESET;
      zeroFlag <= exec_pkg::FLAG_RESET;
      timeoutFlag <= exec_pkg::STATUS_RESET;
      powerDownFlag <= exec_pkg::STATUS_RESET;
      fileWe <= 1'b0;
      fileWaddr <= 7'h00;
      fileWdata <= 8'h00;
      watchdogClear <= 1'b0;
      skipCycle <= 1'b0;
    end else begin
      state_r <= state_nxt;
      accOut <= acc_nxt;
      carryFlag <= c_nxt;
      digitCarryFlag <= digit_nxt;
      zeroFlag <= z_nxt;
      timeoutFlag <= to_nxt;
      powerDownFlag <= pwr_nxt;
      fileWe <= we_nxt;
      fileWaddr <= fwa_nxt;
      fileWdata <= fwd_nxt;
      watchdogClear <= wc_nxt;
      skipCycle <= (state_nxt == exec_pkg::ST_NOP);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence takenSkip;
    instrValid && state_r == exec_pkg::ST_RUN &&
      ((isSkipClr && !testBit) || (isSkipSet && testBit));
  endsequence

  chk_add_imm_result: assert property (@(posedge clk) disable iff (rst)
    (exec && isAddImm) |=> accOut == $past(accOut) + $past(instrWord[7:0]))
    else $error("add immediate result wrong");

  chk_add_reg_dest: assert property (@(posedge clk) disable iff (rst)
    (exec && isAddReg && destReg) |=> fileWe && accOut == $past(accOut))
    else $error("add register destination wrong");

  chk_and_imm_flags: assert property (@(posedge clk) disable iff (rst)
    (exec && isAndImm) |=> carryFlag == $past(carryFlag) && zeroFlag == (accOut == 8'h00))
    else $error("and immediate flags wrong");

  chk_and_reg_acc: assert property (@(posedge clk) disable iff (rst)
    (exec && isAndReg && !destReg) |=> !fileWe && accOut == ($past(accOut) & $past(fileRdata)))
    else $error("and register result wrong");

  chk_bit_clear: assert property (@(posedge clk) disable iff (rst)
    (exec && isBitClr) |=> fileWe && !fileWdata[$past(bitSel)] && $stable(zeroFlag))
    else $error("bit clear wrong");

  chk_bit_set: assert property (@(posedge clk) disable iff (rst)
    (exec && isBitSet) |=> fileWe && fileWdata[$past(bitSel)] && $stable(carryFlag))
    else $error("bit set wrong");

  chk_skip_nop: assert property (@(posedge clk) disable iff (rst)
    takenSkip |=> skipCycle ##1 !skipCycle && !fileWe)
    else $error("skip cycle wrong");

  chk_skip_untaken: assert property (@(posedge clk) disable iff (rst)
    (exec && ((isSkipClr && testBit) || (isSkipSet && !testBit))) |=> !skipCycle)
    else $error("untaken skip stalled");

  chk_watchdog_clear: assert property (@(posedge clk) disable iff (rst)
    (exec && isWatchdogClr) |=> watchdogClear && timeoutFlag && powerDownFlag)
    else $error("watchdog clear wrong");

  chk_nop_holds: assert property (@(posedge clk) disable iff (rst)
    skipCycle |=> $stable(accOut) && !fileWe && !watchdogClear)
    else $error("no-op cycle changed state");

  chk_digit_carry: assert property (@(posedge clk) disable iff (rst)
    (exec && isAddImm) |=> digitCarryFlag ==
      (({1'b0, $past(accOut[3:0])} + {1'b0, $past(instrWord[3:0])}) > 5'h0f))
    else $error("digit carry wrong");

endmodule // instruction_execute_subset
